// [adcc_control.sv]
// Functional notes
// - 24-bit word: mode, gain, flags, filter code
// - Mode zero is normal conversion, reset default
// - Self calibration: shorted zero, reference full
// - System zero-scale step, then normal mode
// - System full-scale step, then normal mode
// - Offset calibration: input zero, reference full
// - Background calibration, word rate divided by six
// - Mode six accesses zero coefficients, select high
// - Mode seven accesses full coefficients, select high
// - Coefficient writes need at least 24 bits; the first 24 are kept
// - Gain equals two to the code power
// - Channel bit picks low or high input
// - Control loads only on 24 or more bits
// - Ready falls on new word, rises after read
// - Power-down bit stops conversion updates
// - Word length bit picks 16 or 24
module adcc_control
  import adcc_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          serial_clock,
  input  wire logic          transmit_frame_n,
  input  wire logic          receive_frame_n,
  input  wire logic          register_select,
  input  wire logic          serial_data_in,
  output logic               serial_data_out,
  output logic               serial_data_oe,
  input  wire logic          conv_valid,
  input  wire logic [23:0]   conv_word,
  output logic               result_ready_n,
  output adcc_ctrl_t         ctrl_word,
  output adcc_cal_t          cal_phase,
  output logic [7:0]         gain_factor
);

  logic [1:0]   rst_sync_r;
  logic         rst_q;
  logic [4:0]   pins;
  adcc_state_t  st_r;
  adcc_state_t  st_nxt;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         wr_end;
  logic         wr_full;
  logic         rd_start;
  logic         conv_take;
  logic         ctrl_load;
  logic [4:0]   rd_cnt_inc;

  // Reset release through two flops; assertion is asynchronous
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_r[1];

  // All five serial input pins come from the microcontroller's domain
  adcc_pin_sync #(
    .W    (5),
    .IDLE (PIN_IDLE)
  ) u_pin_sync (
    .clock   (clock),
    .rst_b   (rst_q),
    .pin_in  ({serial_clock, transmit_frame_n, receive_frame_n, register_select, serial_data_in}),
    .pin_out (pins)
  );

  // Edge and frame events seen on the synchronised pins
  assign sclk_rise  = pins[PIN_SCLK] & ~st_r.sclk_prev;
  assign sclk_fall  = ~pins[PIN_SCLK] & st_r.sclk_prev;
  assign wr_end     = pins[PIN_TXF] & ~st_r.txf_prev;
  assign wr_full    = (st_r.wr_cnt == XFER_FULL_LEN);
  assign rd_start   = ~pins[PIN_RXF] & st_r.rxf_prev;
  assign ctrl_load  = wr_end & wr_full & ~st_r.wr_sel; // A control write restarts the sequence
  assign conv_take  = conv_valid & ~st_r.ctrl.power_down_bit & ~ctrl_load;
  assign rd_cnt_inc = st_r.rd_cnt + 5'h01;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.sclk_prev = pins[PIN_SCLK];
    st_nxt.txf_prev  = pins[PIN_TXF];
    st_nxt.rxf_prev  = pins[PIN_RXF];
    // Gain as a plain factor for the front end
    st_nxt.gain_factor = GAIN_RESET_VAL << st_r.ctrl.gain_select_field;

    // Write frame: shift in on rising edges, stop counting at 24
    if (!pins[PIN_TXF]) begin
      if (st_r.txf_prev) begin
        st_nxt.wr_cnt = 5'h00;
        st_nxt.wr_sel = pins[PIN_SEL];
      end else if (sclk_rise && !wr_full) begin
        st_nxt.wr_sh  = {st_r.wr_sh[22:0], pins[PIN_SDI]};
        st_nxt.wr_cnt = st_r.wr_cnt + 5'h01;
      end
    end

    // Frame end commits only a complete 24-bit word
    if (wr_end && wr_full) begin
      if (!st_r.wr_sel) begin
        st_nxt.ctrl = adcc_ctrl_t'(st_r.wr_sh);
        // The don't-care bit is stored and is read back only by a control register read
        unique case (adcc_mode_t'(st_r.wr_sh[23:21]))
          MODE_SELF_CAL: begin
            st_nxt.cal = CAL_ZERO_SHORTED;
          end
          MODE_SYS_ZERO: begin
            st_nxt.cal = CAL_ZERO_INPUT;
          end
          MODE_SYS_FULL: begin
            st_nxt.cal = CAL_FULL_INPUT;
          end
          MODE_SYS_OFFSET: begin
            st_nxt.cal = CAL_ZERO_INPUT;
          end
          MODE_NORMAL, MODE_BACKGROUND, MODE_ZS_ACCESS, MODE_FS_ACCESS: begin
            st_nxt.cal = CAL_IDLE;
          end
        endcase
        st_nxt.bg_slot = BG_SLOT_DATA;
      end else if (st_r.ctrl.operating_mode_field == MODE_ZS_ACCESS) begin
        st_nxt.zero_coef[st_r.ctrl.input_channel_select] = st_r.wr_sh;
      end else if (st_r.ctrl.operating_mode_field == MODE_FS_ACCESS) begin
        st_nxt.full_coef[st_r.ctrl.input_channel_select] = st_r.wr_sh;
      end
    end

    // Read frame start picks the source and its length
    if (rd_start) begin
      st_nxt.rd_data = 1'b0;
      st_nxt.rd_len  = XFER_FULL_LEN;
      st_nxt.rd_on   = 1'b1;
      if (!pins[PIN_SEL]) begin
        st_nxt.rd_sh = st_r.ctrl;
      end else if (st_r.ctrl.operating_mode_field == MODE_ZS_ACCESS) begin
        st_nxt.rd_sh = st_r.zero_coef[st_r.ctrl.input_channel_select];
      end else if (st_r.ctrl.operating_mode_field == MODE_FS_ACCESS) begin
        st_nxt.rd_sh = st_r.full_coef[st_r.ctrl.input_channel_select];
      end else if (!st_r.ready_n) begin
        // Data register; short words carry the upper 16 bits
        st_nxt.rd_data = 1'b1;
        if (st_r.ctrl.output_word_length_bit) begin
          st_nxt.rd_sh = st_r.result;
        end else begin
          st_nxt.rd_len = XFER_SHORT_LEN;
          st_nxt.rd_sh  = {st_r.result[23:8], 8'h00};
        end
      end else begin
        // No fresh word: the pin stays released
        st_nxt.rd_on = 1'b0;
      end
      st_nxt.rd_cnt = 5'h00;
      st_nxt.sdo    = st_nxt.rd_sh[23];
      st_nxt.sdo_oe = ~st_nxt.rd_on;
    end else if (st_r.rd_on && pins[PIN_RXF]) begin
      // Frame abandoned early; ready stays as it was
      st_nxt.rd_on  = 1'b0;
      st_nxt.sdo_oe = 1'b1;
    end else if (st_r.rd_on && sclk_fall) begin
      st_nxt.rd_sh  = {st_r.rd_sh[22:0], 1'b0};
      st_nxt.sdo    = st_r.rd_sh[22];
      st_nxt.rd_cnt = rd_cnt_inc;
      if (rd_cnt_inc == st_r.rd_len) begin
        st_nxt.rd_on  = 1'b0;
        st_nxt.sdo_oe = 1'b1;
        if (st_r.rd_data) begin
          st_nxt.ready_n = 1'b1;
        end
      end
    end

    // Modulator words: calibration first, then background, then results
    if (conv_take) begin
      if (st_r.cal != CAL_IDLE) begin
        unique case (st_r.cal)
          CAL_ZERO_SHORTED: begin
            st_nxt.zero_coef[st_r.ctrl.input_channel_select] = conv_word;
            st_nxt.cal = CAL_FULL_REF;
          end
          CAL_ZERO_INPUT: begin
            st_nxt.zero_coef[st_r.ctrl.input_channel_select] = conv_word;
            if (st_r.ctrl.operating_mode_field == MODE_SYS_OFFSET) begin
              st_nxt.cal = CAL_FULL_REF;
            end else begin
              st_nxt.cal = CAL_IDLE;
            end
          end
          CAL_FULL_REF, CAL_FULL_INPUT: begin
            st_nxt.full_coef[st_r.ctrl.input_channel_select] = conv_word;
            st_nxt.cal = CAL_IDLE;
          end
          default: begin
            st_nxt.cal = CAL_IDLE;
          end
        endcase
        if (st_nxt.cal == CAL_IDLE) begin
          // Completion: back to normal, ready marks the end
          st_nxt.ctrl.operating_mode_field = MODE_NORMAL;
          st_nxt.ready_n = 1'b0;
        end
      end else if (st_r.ctrl.operating_mode_field == MODE_BACKGROUND) begin
        // Only one slot in six yields a result; two refresh coefficients
        st_nxt.bg_slot = (st_r.bg_slot == BG_RATIO_LAST) ? BG_SLOT_DATA : st_r.bg_slot + 3'h1;
        if (st_r.bg_slot == BG_SLOT_DATA) begin
          st_nxt.result  = conv_word;
          st_nxt.ready_n = 1'b0;
        end else if (st_r.bg_slot == BG_SLOT_ZERO) begin
          st_nxt.zero_coef[st_r.ctrl.input_channel_select] = conv_word;
        end else if (st_r.bg_slot == BG_SLOT_FULL) begin
          st_nxt.full_coef[st_r.ctrl.input_channel_select] = conv_word;
        end
      end else begin
        // New word wins over a read ending in the same cycle
        st_nxt.result  = conv_word;
        st_nxt.ready_n = 1'b0;
      end
    end

    // No result may be announced while a calibration runs
    if (st_nxt.cal != CAL_IDLE) begin
      st_nxt.ready_n = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      st_r             <= '0;
      st_r.ctrl        <= adcc_ctrl_t'(CTRL_RESET_VAL);
      st_r.zero_coef   <= {COEF_RESET_VAL, COEF_RESET_VAL};
      st_r.full_coef   <= {COEF_RESET_VAL, COEF_RESET_VAL};
      st_r.result      <= RESULT_RESET_VAL;
      st_r.sclk_prev   <= PIN_IDLE[PIN_SCLK];
      st_r.txf_prev    <= 1'b1;
      st_r.rxf_prev    <= 1'b1;
      st_r.sdo_oe      <= 1'b1;
      st_r.ready_n     <= 1'b1;
      st_r.cal         <= CAL_IDLE;
      st_r.gain_factor <= GAIN_RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign serial_data_out = st_r.sdo;
  assign serial_data_oe  = st_r.sdo_oe;
  assign result_ready_n  = st_r.ready_n;
  assign ctrl_word       = st_r.ctrl;
  assign cal_phase       = st_r.cal;
  assign gain_factor     = st_r.gain_factor;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_q);

  chk_ctrl_load_full: assert property (
    wr_end && wr_full && !st_r.wr_sel |=> st_r.ctrl.filter_notch_code == $past(st_r.wr_sh[11:0])
  ) else $error("control word not loaded after full write");

  chk_ctrl_short_ignored: assert property (
    wr_end && !wr_full |=> $stable(st_r.ctrl.filter_notch_code) && $stable(st_r.ctrl.gain_select_field)
  ) else $error("short control write changed the register");

  chk_cal_done_normal: assert property (
    conv_take && st_r.cal != CAL_IDLE && st_nxt.cal == CAL_IDLE
      |=> st_r.ctrl.operating_mode_field == MODE_NORMAL && !st_r.ready_n
  ) else $error("calibration end did not restore normal mode");

  chk_sys_zero_start: assert property (
    wr_end && wr_full && !st_r.wr_sel && st_r.wr_sh[23:21] == 3'h2 |=> st_r.cal == CAL_ZERO_INPUT
  ) else $error("system zero step did not start");

  chk_sys_full_start: assert property (
    wr_end && wr_full && !st_r.wr_sel && st_r.wr_sh[23:21] == 3'h3 |=> st_r.cal == CAL_FULL_INPUT
  ) else $error("system full step did not start");

  chk_offset_to_ref: assert property (
    conv_take && st_r.cal == CAL_ZERO_INPUT && st_r.ctrl.operating_mode_field == MODE_SYS_OFFSET
      |=> st_r.cal == CAL_FULL_REF
  ) else $error("offset calibration skipped reference step");

  chk_bg_hold_result: assert property (
    conv_take && st_r.cal == CAL_IDLE && st_r.ctrl.operating_mode_field == MODE_BACKGROUND
      && st_r.bg_slot != BG_SLOT_DATA |=> $stable(st_r.result)
  ) else $error("background slot presented a result");

  chk_zs_write: assert property (
    wr_end && wr_full && st_r.wr_sel && st_r.ctrl.operating_mode_field == MODE_ZS_ACCESS
      |=> st_r.zero_coef[$past(st_r.ctrl.input_channel_select)] == $past(st_r.wr_sh)
  ) else $error("zero coefficient write lost");

  chk_fs_write: assert property (
    wr_end && wr_full && st_r.wr_sel && st_r.ctrl.operating_mode_field == MODE_FS_ACCESS
      |=> st_r.full_coef[$past(st_r.ctrl.input_channel_select)] == $past(st_r.wr_sh)
  ) else $error("full coefficient write lost");

  chk_coef_short: assert property (
    wr_end && !wr_full && st_r.wr_sel && !conv_valid |=> $stable(st_r.zero_coef) && $stable(st_r.full_coef)
  ) else $error("short coefficient write changed a coefficient");

  chk_gain_factor: assert property (
    ##1 $onehot(st_r.gain_factor) && st_r.gain_factor[$past(st_r.ctrl.gain_select_field)]
  ) else $error("gain factor does not match gain code");

  chk_ready_falls: assert property (
    conv_take && st_r.cal == CAL_IDLE && st_r.ctrl.operating_mode_field != MODE_BACKGROUND
      |=> !st_r.ready_n && st_r.result == $past(conv_word)
  ) else $error("new word did not pull ready low");

  chk_pd_freeze: assert property (
    conv_valid && st_r.ctrl.power_down_bit |=> $stable(st_r.result)
  ) else $error("result changed in power-down");

  chk_short_len: assert property (
    rd_start && pins[PIN_SEL] && !st_r.ready_n && st_r.ctrl.operating_mode_field < MODE_ZS_ACCESS
      && !st_r.ctrl.output_word_length_bit |=> st_r.rd_len == XFER_SHORT_LEN && st_r.rd_data
  ) else $error("short word length not applied");

  chk_cal_ready_high: assert property (
    st_r.cal != CAL_IDLE |-> st_r.ready_n && st_r.sdo_oe == ~st_r.rd_on
  ) else $error("ready low during calibration");

  cov_self_cal: cover property (
    st_r.cal == CAL_ZERO_SHORTED ##[1:1000] st_r.cal == CAL_FULL_REF ##[1:1000] st_r.cal == CAL_IDLE
  );
  cov_data_read: cover property (st_r.rd_on && st_r.rd_data ##[1:600] $rose(st_r.ready_n));
  cov_coef_write: cover property (wr_end && wr_full && st_r.wr_sel);
  cov_bg_wrap: cover property (conv_take && st_r.bg_slot == BG_RATIO_LAST);

endmodule

// [adcc_pkg.sv]
package adcc_pkg;

  // Control word and coefficient widths
  localparam int CTRL_BITS   = 24;
  localparam int COEF_BITS   = 24;
  localparam int FILTER_BITS = 12;

  // Serial transfer lengths in bits
  localparam logic [4:0] XFER_FULL_LEN  = 5'h18;
  localparam logic [4:0] XFER_SHORT_LEN = 5'h10;

  // Background calibration: one result per six modulator words
  localparam logic [2:0] BG_RATIO_LAST = 3'h5;
  localparam logic [2:0] BG_SLOT_DATA  = 3'h0;
  localparam logic [2:0] BG_SLOT_ZERO  = 3'h2;
  localparam logic [2:0] BG_SLOT_FULL  = 3'h4;

  // Reset values
  localparam logic [23:0] CTRL_RESET_VAL   = 24'h000000;
  localparam logic [23:0] COEF_RESET_VAL   = 24'h000000;
  localparam logic [23:0] RESULT_RESET_VAL = 24'h000000;
  localparam logic [7:0]  GAIN_RESET_VAL   = 8'h01;

  // Positions of the pins inside the synchronised pin group
  localparam int PIN_SCLK   = 4;
  localparam int PIN_TXF    = 3;
  localparam int PIN_RXF    = 2;
  localparam int PIN_SEL    = 1;
  localparam int PIN_SDI    = 0;
  localparam logic [4:0] PIN_IDLE = 5'h0e;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_SELF_CAL,
    MODE_SYS_ZERO,
    MODE_SYS_FULL,
    MODE_SYS_OFFSET,
    MODE_BACKGROUND,
    MODE_ZS_ACCESS,
    MODE_FS_ACCESS
  } adcc_mode_t;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_ZERO_SHORTED,
    CAL_ZERO_INPUT,
    CAL_FULL_REF,
    CAL_FULL_INPUT
  } adcc_cal_t;

  // Control word, most significant field first
  typedef struct packed {
    adcc_mode_t        operating_mode_field;
    logic [2:0]        gain_select_field;
    logic              input_channel_select;
    logic              power_down_bit;
    logic              output_word_length_bit;
    logic              dont_care_bit;
    logic              burnout_current_bit;
    logic              unipolar_bit;
    logic [11:0]       filter_notch_code;
  } adcc_ctrl_t;

  typedef struct packed {
    adcc_ctrl_t        ctrl;
    logic [1:0][23:0]  zero_coef;
    logic [1:0][23:0]  full_coef;
    logic [23:0]       result;
    logic              sclk_prev;
    logic              txf_prev;
    logic              rxf_prev;
    logic [4:0]        wr_cnt;
    logic [23:0]       wr_sh;
    logic              wr_sel;
    logic              rd_on;
    logic              rd_data;
    logic [4:0]        rd_cnt;
    logic [4:0]        rd_len;
    logic [23:0]       rd_sh;
    logic              sdo;
    logic              sdo_oe;
    logic              ready_n;
    adcc_cal_t         cal;
    logic [2:0]        bg_slot;
    logic [7:0]        gain_factor;
  } adcc_state_t;

endpackage

// [adcc_pin_sync.sv]
module adcc_pin_sync
  import adcc_pkg::*;
#(
  parameter int              W    = 5,
  parameter logic [W-1:0]    IDLE = '0
) (
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic [W-1:0]  pin_in,
  output logic [W-1:0]       pin_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adcc_sync_t;

  adcc_sync_t st_r;
  adcc_sync_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  // Reset to the idle pin levels so no false frame edge appears
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= {IDLE, IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.s2;

endmodule

// [adcc_mcu_model.sv]
// Microcontroller on the serial port: frames, serial clock and write data
module adcc_mcu_model
  import adcc_pkg::*;
(
  input  wire logic clock,
  output logic      serial_clock,
  output logic      transmit_frame_n,
  output logic      receive_frame_n,
  output logic      register_select,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 4;  // Clocks per half of the 80 ns serial period

  logic mcu_bit;
  logic mcu_drive;
  logic idle_bit = 1'b0;

  // Idle levels; the serial clock stands low between frames
  initial begin
    serial_clock = 1'b0;
    transmit_frame_n = 1'b1;
    receive_frame_n = 1'b1;
    register_select = 1'b1;
    mcu_bit = 1'b0;
    mcu_drive = 1'b0;
  end

  // A released data line toggles so a stale value can never look valid
  always @(posedge clock) idle_bit <= ~idle_bit;
  assign serial_data_in = !serial_data_oe ? serial_data_out : (mcu_drive ? mcu_bit : idle_bit);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Write frame, MSB first; bits past the 24th carry filler
  task automatic write_word(input logic sel, input logic [23:0] data, input int nbits);
    register_select = sel;
    transmit_frame_n = 1'b0;
    mcu_drive = 1'b1;
    wait_clk(HALF);
    for (int i = 0; i < nbits; i++) begin
      mcu_bit = (i < 24) ? data[23-i] : i[0];
      wait_clk(HALF);
      serial_clock = 1'b1;
      wait_clk(HALF);
      serial_clock = 1'b0;
    end
    wait_clk(HALF);
    transmit_frame_n = 1'b1;
    mcu_drive = 1'b0;
    register_select = 1'b1;
    wait_clk(8);
  endtask

  // Read frame; bit taken at each serial clock rise
  task automatic read_word(input logic sel, input int nbits, output logic [23:0] data, output logic drove);
    data = '0;
    drove = 1'b0;
    register_select = sel;
    receive_frame_n = 1'b0;
    wait_clk(HALF);
    for (int i = 0; i < nbits; i++) begin
      serial_clock = 1'b1;
      data = {data[22:0], serial_data_in};
      drove = drove | !serial_data_oe;
      wait_clk(HALF);
      serial_clock = 1'b0;
      wait_clk(HALF);
    end
    receive_frame_n = 1'b1;
    register_select = 1'b1;
    wait_clk(8);
  endtask
endmodule

// [adc_control_calibration_modes_tb.sv]
module adc_control_calibration_modes_tb
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock;
  logic        rst_b;
  logic        sclk;
  logic        txf_n;
  logic        rxf_n;
  logic        sel;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        conv_valid;
  logic [23:0] conv_word;
  logic        ready_n;
  adcc_ctrl_t  ctrl_word;
  adcc_cal_t   cal_phase;
  logic [7:0]  gain_factor;
  int          err_count;
  int          n_compared;

  adcc_control u_dut (.clock(clock), .rst_b(rst_b), .serial_clock(sclk), .transmit_frame_n(txf_n),
    .receive_frame_n(rxf_n), .register_select(sel), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_oe(sdo_oe), .conv_valid(conv_valid), .conv_word(conv_word), .result_ready_n(ready_n),
    .ctrl_word(ctrl_word), .cal_phase(cal_phase), .gain_factor(gain_factor));

  adcc_mcu_model u_mcu (.clock(clock), .serial_clock(sclk), .transmit_frame_n(txf_n),
    .receive_frame_n(rxf_n), .register_select(sel), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_oe(sdo_oe));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One modulator word, a single-cycle pulse
  task automatic conv(input logic [23:0] w);
    conv_word = w;
    conv_valid = 1'b1;
    wait_clk(1);
    conv_valid = 1'b0;
    wait_clk(2);
  endtask

  function automatic logic [23:0] mkctrl(input logic [2:0] m, input logic [2:0] g, input logic ch,
                                         input logic pd, input logic wl);
    return {m, g, ch, pd, wl, 3'h0, 12'h0};
  endfunction

  // Expected calibration phase for step s of mode m
  function automatic adcc_cal_t phase_of(input int m, input int s);
    case (m)
      1: return (s == 0) ? CAL_ZERO_SHORTED : CAL_FULL_REF;
      2: return CAL_ZERO_INPUT;
      3: return CAL_FULL_INPUT;
      default: return (s == 0) ? CAL_ZERO_INPUT : CAL_FULL_REF;
    endcase
  endfunction

  // Hang guard, far beyond the roughly 10k cycles of the run
  initial begin
    #1000000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    logic [23:0] w;
    logic [23:0] cur;
    logic [23:0] rd;
    logic [23:0] zc [2];
    logic [23:0] fc [2];
    logic [23:0] bw [6];
    logic        drove;
    logic        ch;
    adcc_cal_t   ph;
    err_count = 0;
    n_compared = 0;
    rst_b = 1'b0;
    conv_valid = 1'b0;
    conv_word = '0;
    zc = '{COEF_RESET_VAL, COEF_RESET_VAL};
    fc = '{COEF_RESET_VAL, COEF_RESET_VAL};
    void'($urandom(32'hb7cbd061));
    wait_clk(4);
    rst_b = 1'b1;
    wait_clk(8);
    check(ctrl_word, CTRL_RESET_VAL, "ctrl reset");
    check(24'(gain_factor), 24'h1, "gain reset");
    check({22'h0, ready_n, sdo_oe}, 24'h3, "pins reset");
    $display("test reset done");
    // Every gain code, random low bits including the ignored one
    for (int g = 0; g < 8; g++) begin
      cur = mkctrl(3'h0, g[2:0], 1'b0, 1'b0, 1'b0) | 24'($urandom & 24'h007fff);
      u_mcu.write_word(1'b0, cur, 24);
      check(ctrl_word & 24'hffbfff, cur & 24'hffbfff, "ctrl load");
      check(24'(gain_factor), 24'h1 << g, "gain");
      check(24'(cal_phase), 24'(CAL_IDLE), "no cal");
      u_mcu.read_word(1'b0, 24, rd, drove);
      check(rd & 24'hffbfff, cur & 24'hffbfff, "ctrl read");
    end
    $display("test gain done");
    // Short write ignored, long write keeps its first 24 bits
    u_mcu.write_word(1'b0, 24'h0e1234, 23);
    check(ctrl_word & 24'hffbfff, cur & 24'hffbfff, "short ctrl");
    cur = mkctrl(3'h0, 3'h2, 1'b0, 1'b0, 1'b1) | 24'h000abc;
    u_mcu.write_word(1'b0, cur, 26);
    check(ctrl_word, cur, "long ctrl");
    $display("test length done");
    // Conversion, 24-bit read, refused read, then 16-bit read, power-down
    w = 24'($urandom);
    conv(w);
    check(24'(ready_n), 24'h0, "ready low");
    u_mcu.read_word(1'b1, 24, rd, drove);
    check(rd, w, "data 24");
    check(24'(ready_n), 24'h1, "ready high");
    u_mcu.read_word(1'b1, 24, rd, drove);
    check(24'(drove), 24'h0, "refused read");
    u_mcu.write_word(1'b0, mkctrl(3'h0, 3'h0, 1'b0, 1'b0, 1'b0), 24);
    w = 24'($urandom);
    conv(w);
    u_mcu.read_word(1'b1, 16, rd, drove);
    check(rd, {8'h00, w[23:8]}, "data 16");
    u_mcu.write_word(1'b0, mkctrl(3'h0, 3'h0, 1'b0, 1'b1, 1'b0), 24);
    conv(24'h5a5a5a);
    check(24'(ready_n), 24'h1, "power down");
    $display("test conversion done");
    // Calibration modes one to four on a random channel
    for (int m = 1; m < 5; m++) begin
      w = 24'($urandom);
      ch = w[0];
      u_mcu.write_word(1'b0, mkctrl(m[2:0], 3'h0, ch, 1'b0, 1'b1), 24);
      for (int s = 0; s < ((m == 1 || m == 4) ? 2 : 1); s++) begin
        ph = phase_of(m, s);
        check(24'(cal_phase), 24'(ph), "cal phase");
        check(24'(ready_n), 24'h1, "ready held");
        w = 24'($urandom);
        if (ph == CAL_ZERO_SHORTED || ph == CAL_ZERO_INPUT) zc[ch] = w;
        else fc[ch] = w;
        conv(w);
      end
      check(24'(ctrl_word[23:21]), 24'h0, "mode back");
      check({20'h0, ready_n, cal_phase}, {21'h0, CAL_IDLE}, "cal end");
    end
    $display("test calibration done");
    // Coefficient writes: full, then short (discarded), word length 16
    for (int m = 6; m < 8; m++) begin
      ch = m[0];
      u_mcu.write_word(1'b0, mkctrl(m[2:0], 3'h0, ch, 1'b0, 1'b0), 24);
      w = 24'($urandom);
      u_mcu.write_word(1'b1, w, 24);
      if (m == 6) zc[ch] = w;
      else fc[ch] = w;
      u_mcu.write_word(1'b1, ~w, 20);
    end
    // Read both coefficient sets of both channels
    for (int k = 0; k < 4; k++) begin
      u_mcu.write_word(1'b0, mkctrl(k[1] ? 3'h7 : 3'h6, 3'h0, k[0], 1'b0, 1'b0), 24);
      u_mcu.read_word(1'b1, 24, rd, drove);
      check(rd, k[1] ? fc[k[0]] : zc[k[0]], "coef read");
    end
    $display("test coefficients done");
    // Background: one result in six words, slots 2 and 4 update coefficients
    u_mcu.write_word(1'b0, mkctrl(3'h5, 3'h0, 1'b0, 1'b0, 1'b1), 24);
    for (int s = 0; s < 6; s++) begin
      bw[s] = 24'($urandom);
      conv(bw[s]);
    end
    u_mcu.read_word(1'b1, 24, rd, drove);
    check(rd, bw[0], "bg result");
    for (int k = 0; k < 2; k++) begin
      u_mcu.write_word(1'b0, mkctrl(k[0] ? 3'h7 : 3'h6, 3'h0, 1'b0, 1'b0, 1'b0), 24);
      u_mcu.read_word(1'b1, 24, rd, drove);
      check(rd, k[0] ? bw[4] : bw[2], "bg coef");
    end
    $display("test background done");
    complete_run();
  end
endmodule
